// >>> irq_mask_id_voltage_select_pin_regs.v
// Interrupt mask, identification and high voltage-select programming registers
// Functional notes
// R1 - Mask register at 02h: bits 7,6,5,2,1,0 sources; bits 4,3 read one.
// R2 - Mask bit 0 lets a source interrupt; mask bit 1 blocks it.
// R3 - Product identification at 03h is a fixed code; writes ignored.
// R4 - Silicon revision at 04h, all eight bits are the revision code.
// R5 - Feature register at 05h: bits 7-4 spare, bits 3-0 feature code.
// R6 - Register 10h: bits 6-0 voltage code, bit 7 enable-pin gating when select high.
// R7 - Acknowledge flags set on both edges of sense, clear on read, reset 00h.
// R8 - Sense register shows live source state in mask bit positions.
// R9 - Interrupt request only when an unmasked acknowledge flag is set.
`include "irq_bank_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module irq_mask_id_voltage_select_pin_regs #(
	parameter [7:0] PRODUCT_CODE = 8'h5a, // Arbitrary value
	parameter [7:0] REVISION_CODE = 8'h01, // Arbitrary value
	parameter [3:0] FEATURE_CODE = 4'h3 // Arbitrary value
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       clkEn,
	input  wire       regWrEn,
	input  wire       regRdEn,
	input  wire [7:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire [7:0] sourceSense,
	input  wire       voltage_select_pin,
	input  wire       enablePin,
	output reg  [7:0] regRdData_ff,
	output reg        irqReq_ff,
	output reg  [6:0] vout_code_select_high_ff,
	output reg        enable_pin_gating_select_high_ff,
	output reg        converterEnable_ff
);
	reg  [7:0] interrupt_source_mask_ff;
	reg  [7:0] liveState_ff;
	reg  [7:0] nxt_mask;
	reg  [6:0] nxt_voutCode;
	reg        nxt_gating;
	reg  [7:0] nxt_liveState;
	reg  [7:0] nxt_rdData;
	reg        nxt_irq;
	reg        nxt_convEn;
	wire [7:0] ackFlags;
	wire [7:0] pendingIrq;
	wire [7:0] productId;
	wire [7:0] revisionId;
	wire [7:0] featureId;
	wire [7:0] maskReadback;
	wire       gatingActive;
	wire       ackRead;
	wire       maskWrite;
	wire       voutWrite;

	// Writes to the identification registers decode to nothing
	assign ackRead    = regRdEn && (regAddr == `ADDR_ACK_FLAGS);
	assign maskWrite  = regWrEn && (regAddr == `ADDR_IRQ_MASK);
	assign voutWrite  = regWrEn && (regAddr == `ADDR_VOUT_SEL_HIGH);
	assign pendingIrq = ackFlags & ~interrupt_source_mask_ff & `SOURCE_BITS; // R2

	assign productId    = PRODUCT_CODE; // R3
	assign revisionId   = REVISION_CODE; // R4
	assign featureId    = {4'h0, FEATURE_CODE}; // R5
	assign maskReadback = interrupt_source_mask_ff | `MASK_SPARE_ONES; // R1
	assign gatingActive = voltage_select_pin && enable_pin_gating_select_high_ff; // R6

	// One flag per source; spare positions carry no flag and read zero
	edge_flag u_flagThermShut ( // R7
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.sense    (sourceSense[`BIT_THERM_SHUT]),
		.clearReq (ackRead),
		.flag_ff  (ackFlags[`BIT_THERM_SHUT])
	);

	edge_flag u_flagThermWarn ( // R7
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.sense    (sourceSense[`BIT_THERM_WARN]),
		.clearReq (ackRead),
		.flag_ff  (ackFlags[`BIT_THERM_WARN])
	);

	edge_flag u_flagThermPrew ( // R7
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.sense    (sourceSense[`BIT_THERM_PREW]),
		.clearReq (ackRead),
		.flag_ff  (ackFlags[`BIT_THERM_PREW])
	);

	edge_flag u_flagUndervolt ( // R7
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.sense    (sourceSense[`BIT_UNDERVOLT]),
		.clearReq (ackRead),
		.flag_ff  (ackFlags[`BIT_UNDERVOLT])
	);

	edge_flag u_flagOvercurrent ( // R7
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.sense    (sourceSense[`BIT_OVERCURRENT]),
		.clearReq (ackRead),
		.flag_ff  (ackFlags[`BIT_OVERCURRENT])
	);

	edge_flag u_flagPowerGood ( // R7
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.sense    (sourceSense[`BIT_POWER_GOOD]),
		.clearReq (ackRead),
		.flag_ff  (ackFlags[`BIT_POWER_GOOD])
	);

	assign ackFlags[4:3] = 2'b00;

	// Spare bits forced high on every write, so a read never shows them low
	always @* begin
		if (maskWrite)
			nxt_mask = regWrData | `MASK_SPARE_ONES; // R1
		else
			nxt_mask = interrupt_source_mask_ff;
	end

	always @* begin
		if (voutWrite) begin
			nxt_voutCode = regWrData[`VOUT_CODE_MSB:0]; // R6
			nxt_gating   = regWrData[`GATING_EN_BIT]; // R6
		end else begin
			nxt_voutCode = vout_code_select_high_ff;
			nxt_gating   = enable_pin_gating_select_high_ff;
		end
	end

	// Live state lags the pins by one cycle
	always @* begin
		nxt_liveState = sourceSense & `SOURCE_BITS; // R8
	end

	// Flags kept unmasked, so clearing a mask bit later still raises a pending event
	always @* begin
		nxt_irq = |pendingIrq; // R9
	end

	always @* begin
		case (regAddr)
			`ADDR_ACK_FLAGS:     nxt_rdData = ackFlags; // R7
			`ADDR_LIVE_STATE:    nxt_rdData = liveState_ff; // R8
			`ADDR_IRQ_MASK:      nxt_rdData = maskReadback; // R1
			`ADDR_PRODUCT_ID:    nxt_rdData = productId; // R3
			`ADDR_SILICON_REV:   nxt_rdData = revisionId; // R4
			`ADDR_FEATURE_CFG:   nxt_rdData = featureId; // R5
			`ADDR_VOUT_SEL_HIGH: nxt_rdData = {enable_pin_gating_select_high_ff, vout_code_select_high_ff}; // R6
			default:             nxt_rdData = 8'h00;
		endcase
	end

	// Gating only applies while the select pin chooses this register
	always @* begin
		if (gatingActive)
			nxt_convEn = enablePin; // R6
		else
			nxt_convEn = 1'b1;
	end

	// A low clock enable holds every register below
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			interrupt_source_mask_ff <= `RST_IRQ_MASK;
		end else if (clkEn) begin
			interrupt_source_mask_ff <= nxt_mask;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vout_code_select_high_ff         <= `RST_VOUT_CODE;
			enable_pin_gating_select_high_ff <= `RST_GATING_EN;
		end else if (clkEn) begin
			vout_code_select_high_ff         <= nxt_voutCode;
			enable_pin_gating_select_high_ff <= nxt_gating;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			liveState_ff <= `RST_LIVE_STATE;
		end else if (clkEn) begin
			liveState_ff <= nxt_liveState;
		end
	end

	// Read data holds until the next read, so a slow host may sample late
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdData_ff <= `RST_RD_DATA;
		end else if (clkEn && regRdEn) begin
			regRdData_ff <= nxt_rdData;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqReq_ff <= `RST_IRQ_REQ;
		end else if (clkEn) begin
			irqReq_ff <= nxt_irq; // R2 R9
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			converterEnable_ff <= `RST_CONV_EN;
		end else if (clkEn) begin
			converterEnable_ff <= nxt_convEn;
		end
	end
endmodule // irq_mask_id_voltage_select_pin_regs
`default_nettype wire

// >>> irq_bank_defs.vh
// Register offsets, field positions and reset values of the interrupt/id/voltage bank
`ifndef IRQ_BANK_DEFS_VH
`define IRQ_BANK_DEFS_VH
`define ADDR_ACK_FLAGS     8'h00
`define ADDR_LIVE_STATE    8'h01
`define ADDR_IRQ_MASK      8'h02
`define ADDR_PRODUCT_ID    8'h03
`define ADDR_SILICON_REV   8'h04
`define ADDR_FEATURE_CFG   8'h05
`define ADDR_VOUT_SEL_HIGH 8'h10
`define BIT_THERM_SHUT     7
`define BIT_THERM_WARN     6
`define BIT_THERM_PREW     5
`define BIT_UNDERVOLT      2
`define BIT_OVERCURRENT    1
`define BIT_POWER_GOOD     0
`define SOURCE_BITS        8'he7
`define MASK_SPARE_ONES    8'h18
`define RST_IRQ_MASK       8'hff
`define RST_ACK_FLAGS      8'h00
`define RST_VOUT_SEL_HIGH  8'h00
`define RST_VOUT_CODE      7'h00
`define RST_GATING_EN      1'h0
`define RST_LIVE_STATE     8'h00
`define RST_RD_DATA        8'h00
`define RST_IRQ_REQ        1'h0
`define RST_CONV_EN        1'h1
`define VOUT_CODE_MSB      6
`define GATING_EN_BIT      7
`endif

// >>> edge_flag.v
// One acknowledge flag: set on either edge of its sense input, cleared on read
`timescale 1ns/1ps
`default_nettype none
module edge_flag (
	input  wire core_clk,
	input  wire rst,
	input  wire clkEn,
	input  wire sense,
	input  wire clearReq,
	output reg  flag_ff
);
	reg senseDly_ff;
	wire nxt_flag;

	// Set wins over a read-clear in the same cycle so no event is lost
	assign nxt_flag = (sense ^ senseDly_ff) | (flag_ff & ~clearReq); // R7

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			senseDly_ff <= 1'b0;
			flag_ff     <= 1'b0;
		end else if (clkEn) begin
			senseDly_ff <= sense;
			flag_ff     <= nxt_flag;
		end
	end
endmodule // edge_flag
`default_nettype wire

// >>> host_model.sv
// Host model issuing single-byte register transfers
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       core_clk,
	output var  logic       regWrEn   = 1'h0,
	output var  logic       regRdEn   = 1'h0,
	output var  logic [7:0] regAddr   = 8'h00,
	output var  logic [7:0] regWrData = 8'h00
);
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		{regWrEn, regRdEn, regAddr, regWrData} = {w, !w, a, d};
		@(posedge core_clk) #1;
		// Released bus shows junk, not the last value
		{regWrEn, regRdEn, regAddr, regWrData} = {2'b00, ~a, ~d};
	endtask
endmodule // host_model
`default_nettype wire

// >>> irq_bank_props.sv
// Port assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module irq_chk (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       clkEn,
	input wire logic       regRdEn,
	input wire logic       regWrEn,
	input wire logic       voltage_select_pin,
	input wire logic       enablePin,
	input wire logic       irqReq_ff,
	input wire logic       converterEnable_ff,
	input wire logic       enable_pin_gating_select_high_ff,
	input wire logic [6:0] vout_code_select_high_ff,
	input wire logic [7:0] sourceSense,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData_ff
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_spare; clkEn && regRdEn && regAddr == 8'h02 |=> regRdData_ff[4:3] == 2'b11; endproperty
	a_spare: assert property (p_spare) else $error("mask spare bits low");
	property p_mask; clkEn && regWrEn && regAddr == 8'h02 && regWrData == 8'hff ##1 clkEn |=> !irqReq_ff;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_gate; clkEn && !voltage_select_pin |=> converterEnable_ff; endproperty
	a_gate: assert property (p_gate) else $error("gated with select low");
	property p_feat; clkEn && regRdEn && regAddr == 8'h05 |=> regRdData_ff[7:4] == 4'h0; endproperty
	a_feat: assert property (p_feat) else $error("feature spare bits set");
	property p_voltage_select_pin;
		clkEn && regWrEn && regAddr == 8'h10
			|=> {enable_pin_gating_select_high_ff, vout_code_select_high_ff} == $past(regWrData);
	endproperty
	a_voltage_select_pin: assert property (p_voltage_select_pin) else $error("voltage register write lost");
	property p_gating;
		clkEn && voltage_select_pin && enable_pin_gating_select_high_ff
			|=> converterEnable_ff == $past(enablePin);
	endproperty
	a_gating: assert property (p_gating) else $error("enable pin gating wrong");
	property p_live;
		clkEn && $past(clkEn) && regRdEn && regAddr == 8'h01
			|=> regRdData_ff == ($past(sourceSense, 2) & 8'he7);
	endproperty
	a_live: assert property (p_live) else $error("live state read wrong");
endmodule // irq_chk
bind irq_mask_id_voltage_select_pin_regs irq_chk u_props (
	.core_clk                         (core_clk),
	.rst                              (rst),
	.clkEn                            (clkEn),
	.regRdEn                          (regRdEn),
	.regWrEn                          (regWrEn),
	.voltage_select_pin               (voltage_select_pin),
	.enablePin                        (enablePin),
	.irqReq_ff                        (irqReq_ff),
	.converterEnable_ff               (converterEnable_ff),
	.enable_pin_gating_select_high_ff (enable_pin_gating_select_high_ff),
	.vout_code_select_high_ff         (vout_code_select_high_ff),
	.sourceSense                      (sourceSense),
	.regAddr                          (regAddr),
	.regWrData                        (regWrData),
	.regRdData_ff                     (regRdData_ff)
);
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       core_clk           = 1'h0;
	logic       rst                = 1'h1;
	logic       clkEn              = 1'h1;
	logic       voltage_select_pin = 1'h1;
	logic       enablePin          = 1'h0;
	logic       regWrEn;
	logic       regRdEn;
	logic       irqReq_ff;
	logic       enable_pin_gating_select_high_ff;
	logic       converterEnable_ff;
	logic [6:0] vout_code_select_high_ff;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic [7:0] sourceSense        = 8'h00;
	logic [7:0] regRdData_ff;
	logic [7:0] s;
	logic [7:0] q[$];
	int         bad_count          = 0;
	int         cmp_count          = 0;
	integer     seed               = 32'h255e;
	always #10 core_clk = ~core_clk;
	irq_mask_id_voltage_select_pin_regs dut (
		.core_clk                         (core_clk),
		.rst                              (rst),
		.clkEn                            (clkEn),
		.regWrEn                          (regWrEn),
		.regRdEn                          (regRdEn),
		.regAddr                          (regAddr),
		.regWrData                        (regWrData),
		.sourceSense                      (sourceSense),
		.voltage_select_pin               (voltage_select_pin),
		.enablePin                        (enablePin),
		.regRdData_ff                     (regRdData_ff),
		.irqReq_ff                        (irqReq_ff),
		.vout_code_select_high_ff         (vout_code_select_high_ff),
		.enable_pin_gating_select_high_ff (enable_pin_gating_select_high_ff),
		.converterEnable_ff               (converterEnable_ff)
	);
	host_model h (
		.core_clk  (core_clk),
		.regWrEn   (regWrEn),
		.regRdEn   (regRdEn),
		.regAddr   (regAddr),
		.regWrData (regWrData)
	);
	task chk(input logic [7:0] v, e);
		cmp_count++;
		if (v !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, v, e);
		end
	endtask
	task t(input logic w, input logic [7:0] a, d);
		if (!w) q.push_back(d);
		h.xfer(w, a, w ? d : 8'h00);
	endtask
	task close_out;
		if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) if (regRdEn && clkEn) #2 chk(regRdData_ff, q.pop_front());
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		#1 rst = 0;
		t(0, 8'h02, 8'hff);
		t(1, 8'h02, 8'h00);
		t(0, 8'h02, 8'h18);
		t(1, 8'h03, 8'h00);
		t(0, 8'h03, 8'h5a);
		t(0, 8'h04, 8'h01);
		t(0, 8'h05, 8'h03);
		t(1, 8'h10, 8'h85);
		t(0, 8'h10, 8'h85);
		chk({enable_pin_gating_select_high_ff, vout_code_select_high_ff}, 8'h85);
		chk({7'h0, converterEnable_ff}, 8'h00);
		enablePin = 1'h1;
		repeat (2) @(posedge core_clk);
		#1 chk({7'h0, converterEnable_ff}, 8'h01);
		// A write while frozen must not land
		clkEn = 1'h0;
		t(1, 8'h10, 8'h00);
		clkEn = 1'h1;
		chk({enable_pin_gating_select_high_ff, vout_code_select_high_ff}, 8'h85);
		t(0, 8'h00, 8'h00);
		sourceSense = $random(seed) | 8'h01;
		s = sourceSense & 8'he7;
		t(0, 8'h01, s);
		chk({7'h0, irqReq_ff}, 8'h01);
		t(0, 8'h00, s);
		t(0, 8'h00, 8'h00);
		chk({7'h0, irqReq_ff}, 8'h00);
		t(1, 8'h02, 8'hff);
		sourceSense = 0;
		repeat (3) @(posedge core_clk);
		#1 chk({7'h0, irqReq_ff}, 8'h00);
		voltage_select_pin = 1'h0;
		enablePin = 1'h0;
		t(0, 8'h00, s);
		chk({7'h0, converterEnable_ff}, 8'h01);
		// Let the watcher compare the last read before closing
		@(posedge core_clk);
		#1 close_out;
	end
endmodule // testbench
`default_nettype wire
